// >>> src/cit_consts.vh
// Constants for the camera I/O and acquisition trigger block.
// Included by the design file; definitions only.
`ifndef CIT_CONSTS_VH
`define CIT_CONSTS_VH

// System clock rate and the unit of every programmed time
`define CIT_CLK_MHZ         20
`define CIT_UNIT_US         1
`define CIT_SUB_W           5
`define CIT_TIME_W          16
`define CIT_SEQ_W           24

// Output source codes
`define CIT_SRC_W           4
`define CIT_SRC_OFF         4'h0
`define CIT_SRC_HOST        4'h1
`define CIT_SRC_FRAME_BEGIN 4'h2
`define CIT_SRC_INTEG_BEGIN 4'h3
`define CIT_SRC_INTEG_END   4'h4
`define CIT_SRC_XFER_BEGIN  4'h5
`define CIT_SRC_XFER_END    4'h6
`define CIT_SRC_ACCEPTED    4'h7
`define CIT_SRC_REJECTED    4'h8
`define CIT_SRC_TIMER_DONE  4'h9
`define CIT_SRC_CNTR_DONE   4'ha
`define CIT_SRC_INPUT_ONE   4'hb
`define CIT_SRC_INPUT_TWO   4'hc
`define CIT_SRC_LINK        4'hd
`define CIT_SRC_INTEG_LEVEL 4'he
`define CIT_SRC_NUM         16

// Pulse edge select codes
`define CIT_EDGE_W          2
`define CIT_EDGE_UP         2'h0
`define CIT_EDGE_DOWN       2'h1
`define CIT_EDGE_BOTH       2'h2

// Start source codes
`define CIT_TSRC_W          3
`define CIT_TSRC_PIN_ONE    3'h0
`define CIT_TSRC_PIN_TWO    3'h1
`define CIT_TSRC_LINK       3'h2
`define CIT_TSRC_TIMER      3'h3
`define CIT_TSRC_COUNTER    3'h4
`define CIT_TSRC_SOFTWARE   3'h5

// Early start policy codes
`define CIT_POLICY_OFF      1'b0
`define CIT_POLICY_READOUT  1'b1

// Sensor gap between integration end and transfer begin, in cycles
`define CIT_GAP_CYCLES      8

`endif

// >>> src/cit_io_trigger.v
// Camera digital I/O and acquisition trigger control: input filters, output
// source multiplexers with pulse generators, and the frame sequencer.
// Assumes one 20 MHz clock; pins and the link request are asynchronous.
`timescale 1ns/1ps
`include "cit_consts.vh"

module cit_io_trigger #(
  parameter NIN  = 2,
  parameter NOUT = 4
) (
  input  wire                            CLK_SYS,
  input  wire                            RST_N,
  input  wire [NIN-1:0]                  INPUT_PIN,
  input  wire                            LINK_REQUEST_ZERO,
  input  wire                            FIRST_TIMER_DONE_EVENT,
  input  wire                            FIRST_COUNTER_DONE_EVENT,
  input  wire                            SOFTWARE_START,
  input  wire [`CIT_TIME_W-1:0]          INPUT_GLITCH_FILTER_TIME,
  input  wire [NIN+NOUT-1:0]             PIN_POLARITY_FLIP,
  input  wire [NOUT-1:0]                 PIN_DIRECTION,
  input  wire [NOUT*`CIT_SRC_W-1:0]      OUTPUT_SOURCE_SELECT,
  input  wire [NOUT*`CIT_EDGE_W-1:0]     PULSE_EDGE_SELECT,
  input  wire [NOUT*`CIT_TIME_W-1:0]     PULSE_LEAD_TIME,
  input  wire [NOUT*`CIT_TIME_W-1:0]     PULSE_WIDTH_TIME,
  input  wire [NOUT-1:0]                 HOST_OUTPUT_LEVEL,
  input  wire                            EXTERNAL_START_ENABLE,
  input  wire [`CIT_TSRC_W-1:0]          START_SOURCE_SELECT,
  input  wire                            EARLY_START_POLICY,
  input  wire [`CIT_SEQ_W-1:0]           INTEGRATION_TIME,
  input  wire [`CIT_SEQ_W-1:0]           TRANSFER_TIME,
  input  wire [`CIT_SEQ_W-1:0]           FRAME_PERIOD_TIME,
  output wire [NOUT-1:0]                 OUTPUT_PIN_O,
  output wire [NOUT-1:0]                 OUTPUT_PIN_OE,
  output wire [NIN+NOUT-1:0]             LINE_STATUS,
  output wire                            FRAME_ACTIVE,
  output wire                            INTEGRATION_ACTIVE,
  output wire                            TRANSFER_ACTIVE
);

  localparam US_CYC = `CIT_CLK_MHZ * `CIT_UNIT_US;
  localparam [`CIT_SUB_W-1:0] US_LAST = US_CYC - 1;
  localparam [`CIT_SEQ_W-1:0] GAP_LAST = `CIT_GAP_CYCLES - 1;

  localparam [1:0] SQ_IDLE  = 2'h0;
  localparam [1:0] SQ_INTEG = 2'h1;
  localparam [1:0] SQ_GAP   = 2'h2;
  localparam [1:0] SQ_XFER  = 2'h3;

  localparam [1:0] PG_IDLE  = 2'h0;
  localparam [1:0] PG_LEAD  = 2'h1;
  localparam [1:0] PG_PULSE = 2'h2;

  // Input pins: synchronise, filter, then apply polarity
  wire [NIN-1:0] in_level;
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_in
      reg                   sync1_ff;
      reg                   sync2_ff;
      reg                   stable_ff;
      reg [`CIT_SUB_W-1:0]  sub_ff;
      reg [`CIT_TIME_W-1:0] cnt_ff;
      always @(posedge CLK_SYS) begin
        if (!RST_N) begin
          sync1_ff  <= 1'b0;
          sync2_ff  <= 1'b0;
          stable_ff <= 1'b0;
          sub_ff    <= {`CIT_SUB_W{1'b0}};
          cnt_ff    <= {`CIT_TIME_W{1'b0}};
        end else begin
          sync1_ff <= INPUT_PIN[gi];
          sync2_ff <= sync1_ff;
          if (sync2_ff == stable_ff) begin
            sub_ff <= {`CIT_SUB_W{1'b0}};
            cnt_ff <= {`CIT_TIME_W{1'b0}};
          end else if (cnt_ff == INPUT_GLITCH_FILTER_TIME) begin
            stable_ff <= sync2_ff;
            sub_ff    <= {`CIT_SUB_W{1'b0}};
            cnt_ff    <= {`CIT_TIME_W{1'b0}};
          end else if (sub_ff == US_LAST) begin
            sub_ff <= {`CIT_SUB_W{1'b0}};
            cnt_ff <= cnt_ff + 1'b1;
          end else begin
            sub_ff <= sub_ff + 1'b1;
          end
        end
      end
      assign in_level[gi] = stable_ff ^ PIN_POLARITY_FLIP[gi];
    end
  endgenerate

  // Link request synchroniser
  reg link_s1_ff;
  reg link_s2_ff;
  reg link_d_ff;
  reg [NIN-1:0] in_d_ff;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      link_s1_ff <= 1'b0;
      link_s2_ff <= 1'b0;
      link_d_ff  <= 1'b0;
      in_d_ff    <= {NIN{1'b0}};
    end else begin
      link_s1_ff <= LINK_REQUEST_ZERO;
      link_s2_ff <= link_s1_ff;
      link_d_ff  <= link_s2_ff;
      in_d_ff    <= in_level;
    end
  end

  // Start event from the selected source
  reg trig_evt;
  always @* begin
    case (START_SOURCE_SELECT)
      `CIT_TSRC_PIN_ONE:  trig_evt = in_level[0] & ~in_d_ff[0];
      `CIT_TSRC_PIN_TWO:  trig_evt = in_level[1] & ~in_d_ff[1];
      `CIT_TSRC_LINK:     trig_evt = link_s2_ff & ~link_d_ff;
      `CIT_TSRC_TIMER:    trig_evt = FIRST_TIMER_DONE_EVENT;
      `CIT_TSRC_COUNTER:  trig_evt = FIRST_COUNTER_DONE_EVENT;
      `CIT_TSRC_SOFTWARE: trig_evt = SOFTWARE_START;
      default:            trig_evt = 1'b0;
    endcase
  end

  // Frame sequencer
  reg [1:0]            sq_ff;
  reg [1:0]            nxt_sq;
  reg [`CIT_SUB_W-1:0] sq_sub_ff;
  reg [`CIT_SEQ_W-1:0] sq_cnt_ff;
  reg                  pend_ff;
  reg [`CIT_SUB_W-1:0] fp_sub_ff;
  reg [`CIT_SEQ_W-1:0] fp_cnt_ff;
  reg                  free_req_ff;
  reg                  accept_ff;
  reg                  reject_ff;

  wire sq_done = (sq_ff == SQ_GAP) ? (sq_cnt_ff == GAP_LAST) :
                 (sq_ff == SQ_INTEG) ? (sq_cnt_ff >= INTEGRATION_TIME) :
                 (sq_cnt_ff >= TRANSFER_TIME);
  wire can_accept = (sq_ff == SQ_IDLE) & ~pend_ff |
                    (EARLY_START_POLICY == `CIT_POLICY_READOUT) & (sq_ff == SQ_XFER) & ~pend_ff;
  wire trig_take = EXTERNAL_START_ENABLE & trig_evt & can_accept;
  wire trig_drop = EXTERNAL_START_ENABLE & trig_evt & ~can_accept;
  wire start_req = EXTERNAL_START_ENABLE ? pend_ff : free_req_ff;
  wire fp_wrap   = (fp_cnt_ff >= FRAME_PERIOD_TIME) & (fp_sub_ff == US_LAST);

  always @* begin
    nxt_sq = sq_ff;
    case (sq_ff)
      SQ_IDLE:  if (start_req) nxt_sq = SQ_INTEG;
      SQ_INTEG: if (sq_done) nxt_sq = SQ_GAP;
      SQ_GAP:   if (sq_done) nxt_sq = SQ_XFER;
      SQ_XFER:  if (sq_done) nxt_sq = start_req ? SQ_INTEG : SQ_IDLE;
      default:  nxt_sq = SQ_IDLE;
    endcase
  end

  wire sq_move = (nxt_sq != sq_ff) | ((sq_ff == SQ_XFER) & sq_done);
  wire ev_integ_begin = sq_move & (nxt_sq == SQ_INTEG);
  wire ev_integ_end   = (sq_ff == SQ_INTEG) & sq_done;
  wire ev_xfer_begin  = (sq_ff == SQ_GAP) & sq_done;
  wire ev_xfer_end    = (sq_ff == SQ_XFER) & sq_done;

  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      sq_ff       <= SQ_IDLE;
      sq_sub_ff   <= {`CIT_SUB_W{1'b0}};
      sq_cnt_ff   <= {`CIT_SEQ_W{1'b0}};
      pend_ff     <= 1'b0;
      fp_sub_ff   <= {`CIT_SUB_W{1'b0}};
      fp_cnt_ff   <= {`CIT_SEQ_W{1'b0}};
      free_req_ff <= 1'b0;
      accept_ff   <= 1'b0;
      reject_ff   <= 1'b0;
    end else begin
      sq_ff     <= nxt_sq;
      accept_ff <= trig_take;
      reject_ff <= trig_drop;
      if (sq_move) begin
        sq_sub_ff <= {`CIT_SUB_W{1'b0}};
        sq_cnt_ff <= {`CIT_SEQ_W{1'b0}};
      end else if (sq_ff == SQ_GAP || sq_sub_ff == US_LAST) begin
        sq_sub_ff <= {`CIT_SUB_W{1'b0}};
        sq_cnt_ff <= sq_cnt_ff + 1'b1;
      end else begin
        sq_sub_ff <= sq_sub_ff + 1'b1;
      end
      // Accepted trigger waits for idle or transfer end
      if (trig_take)
        pend_ff <= 1'b1;
      else if (ev_integ_begin || !EXTERNAL_START_ENABLE)
        pend_ff <= 1'b0;
      // Free run period counter; a late frame waits until idle or transfer end
      if (EXTERNAL_START_ENABLE || fp_wrap) begin
        fp_sub_ff <= {`CIT_SUB_W{1'b0}};
        fp_cnt_ff <= {`CIT_SEQ_W{1'b0}};
      end else if (fp_sub_ff == US_LAST) begin
        fp_sub_ff <= {`CIT_SUB_W{1'b0}};
        fp_cnt_ff <= fp_cnt_ff + 1'b1;
      end else begin
        fp_sub_ff <= fp_sub_ff + 1'b1;
      end
      if (EXTERNAL_START_ENABLE)
        free_req_ff <= 1'b0;
      else if (fp_wrap)
        free_req_ff <= 1'b1;
      else if (ev_integ_begin)
        free_req_ff <= 1'b0;
    end
  end

  wire integ_level = (sq_ff == SQ_INTEG);

  // Source signals indexed by output source code
  wire [`CIT_SRC_NUM-1:0] src_sig;
  assign src_sig[0]  = 1'b0;
  assign src_sig[1]  = 1'b0;
  assign src_sig[2]  = ev_integ_begin;
  assign src_sig[3]  = ev_integ_begin;
  assign src_sig[4]  = ev_integ_end;
  assign src_sig[5]  = ev_xfer_begin;
  assign src_sig[6]  = ev_xfer_end;
  assign src_sig[7]  = accept_ff;
  assign src_sig[8]  = reject_ff;
  assign src_sig[9]  = FIRST_TIMER_DONE_EVENT;
  assign src_sig[10] = FIRST_COUNTER_DONE_EVENT;
  assign src_sig[11] = in_level[0];
  assign src_sig[12] = in_level[1];
  assign src_sig[13] = link_s2_ff;
  assign src_sig[14] = 1'b0;
  assign src_sig[15] = 1'b0;

  // Output lines: edge detect, lead, pulse, multiplex
  genvar go;
  generate
    for (go = 0; go < NOUT; go = go + 1) begin : g_out
      wire [`CIT_SRC_W-1:0]  sel  = OUTPUT_SOURCE_SELECT[go*`CIT_SRC_W +: `CIT_SRC_W];
      wire [`CIT_EDGE_W-1:0] esel = PULSE_EDGE_SELECT[go*`CIT_EDGE_W +: `CIT_EDGE_W];
      wire [`CIT_TIME_W-1:0] lead = PULSE_LEAD_TIME[go*`CIT_TIME_W +: `CIT_TIME_W];
      wire [`CIT_TIME_W-1:0] wdth = PULSE_WIDTH_TIME[go*`CIT_TIME_W +: `CIT_TIME_W];
      wire                   s    = src_sig[sel];
      reg                    s_d_ff;
      reg  [1:0]             pg_ff;
      reg  [`CIT_SUB_W-1:0]  sub_ff;
      reg  [`CIT_TIME_W-1:0] cnt_ff;
      reg                    out_ff;
      reg                    oe_ff;
      reg                    lvl;
      wire rise = s & ~s_d_ff;
      wire fall = ~s & s_d_ff;
      wire hit  = (esel == `CIT_EDGE_UP)   ? rise :
                  (esel == `CIT_EDGE_DOWN) ? fall :
                  (esel == `CIT_EDGE_BOTH) ? (rise | fall) : 1'b0;
      wire limit = (pg_ff == PG_LEAD) ? (cnt_ff == lead) : (cnt_ff == wdth);
      always @* begin
        case (sel)
          `CIT_SRC_HOST:        lvl = HOST_OUTPUT_LEVEL[go];
          `CIT_SRC_INTEG_LEVEL: lvl = integ_level;
          default:              lvl = (pg_ff == PG_PULSE);
        endcase
      end
      always @(posedge CLK_SYS) begin
        if (!RST_N) begin
          s_d_ff <= 1'b0;
          pg_ff  <= PG_IDLE;
          sub_ff <= {`CIT_SUB_W{1'b0}};
          cnt_ff <= {`CIT_TIME_W{1'b0}};
          out_ff <= 1'b0;
          oe_ff  <= 1'b0;
        end else begin
          s_d_ff <= s;
          out_ff <= lvl ^ PIN_POLARITY_FLIP[NIN+go];
          oe_ff  <= PIN_DIRECTION[go] & (sel != `CIT_SRC_OFF);
          case (pg_ff)
            PG_IDLE: begin
              sub_ff <= {`CIT_SUB_W{1'b0}};
              cnt_ff <= {`CIT_TIME_W{1'b0}};
              if (hit && sel >= `CIT_SRC_FRAME_BEGIN && sel <= `CIT_SRC_LINK)
                pg_ff <= PG_LEAD;
            end
            PG_LEAD, PG_PULSE: begin
              if (limit) begin
                sub_ff <= {`CIT_SUB_W{1'b0}};
                cnt_ff <= {`CIT_TIME_W{1'b0}};
                if (pg_ff == PG_LEAD && wdth != {`CIT_TIME_W{1'b0}})
                  pg_ff <= PG_PULSE;
                else
                  pg_ff <= PG_IDLE;
              end else if (sub_ff == US_LAST) begin
                sub_ff <= {`CIT_SUB_W{1'b0}};
                cnt_ff <= cnt_ff + 1'b1;
              end else begin
                sub_ff <= sub_ff + 1'b1;
              end
            end
            default: pg_ff <= PG_IDLE;
          endcase
        end
      end
      assign OUTPUT_PIN_O[go]       = out_ff;
      assign OUTPUT_PIN_OE[go]      = oe_ff;
      assign LINE_STATUS[NIN+go]    = out_ff;
    end
  endgenerate

  assign LINE_STATUS[NIN-1:0] = in_level;
  assign FRAME_ACTIVE         = (sq_ff != SQ_IDLE);
  assign INTEGRATION_ACTIVE   = integ_level;
  assign TRANSFER_ACTIVE      = (sq_ff == SQ_XFER);

endmodule

// >>> verification/cit_grabber_model.sv
// Frame grabber and trigger equipment model driving the input pins and link request.
// Assumes go is pulsed one cycle by the bench; opto inputs idle low once released.
`timescale 1ns/1ps
module cit_grabber_model (
  input  wire logic       clk,
  input  wire logic [2:0] go,
  input  wire logic [7:0] len,
  output logic      [1:0] pin,
  output logic            link
);
  logic [7:0] cnt_ff [3];
  initial begin
    pin = 2'h0;
    link = 1'b0;
    cnt_ff = '{8'h0, 8'h0, 8'h0};
  end
  // Each request holds its line high for len cycles, then lets it fall
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) cnt_ff[i] <= go[i] ? len : (cnt_ff[i] != 8'h0 ? cnt_ff[i] - 8'h1 : 8'h0);
    pin <= {go[1] || cnt_ff[1] > 8'h1, go[0] || cnt_ff[0] > 8'h1};
    link <= go[2] || cnt_ff[2] > 8'h1;
  end
endmodule

// >>> verification/cit_io_trigger_sva.sv
// Port assertions for cit_io_trigger: line 0 output, input one, frame sequence.
// Assumes binding by name to cit_io_trigger and one clock domain.
`timescale 1ns/1ps
`include "cit_consts.vh"
module cit_io_trigger_sva #(parameter NIN = 2, parameter NOUT = 4) (
  input wire logic                        CLK_SYS,
  input wire logic                        RST_N,
  input wire logic [NIN-1:0]              INPUT_PIN,
  input wire logic                        SOFTWARE_START,
  input wire logic [`CIT_TIME_W-1:0]      INPUT_GLITCH_FILTER_TIME,
  input wire logic [NIN+NOUT-1:0]         PIN_POLARITY_FLIP,
  input wire logic [NOUT-1:0]             PIN_DIRECTION,
  input wire logic [NOUT*`CIT_SRC_W-1:0]  OUTPUT_SOURCE_SELECT,
  input wire logic [NOUT*`CIT_TIME_W-1:0] PULSE_WIDTH_TIME,
  input wire logic [NOUT-1:0]             HOST_OUTPUT_LEVEL,
  input wire logic                        EXTERNAL_START_ENABLE,
  input wire logic                        EARLY_START_POLICY,
  input wire logic [`CIT_TSRC_W-1:0]      START_SOURCE_SELECT,
  input wire logic [`CIT_SEQ_W-1:0]       INTEGRATION_TIME,
  input wire logic [NOUT-1:0]             OUTPUT_PIN_O,
  input wire logic [NOUT-1:0]             OUTPUT_PIN_OE,
  input wire logic [NIN+NOUT-1:0]         LINE_STATUS,
  input wire logic                        FRAME_ACTIVE,
  input wire logic                        INTEGRATION_ACTIVE,
  input wire logic                        TRANSFER_ACTIVE
);
  logic [3:0]  src0;
  logic [23:0] hi_ff, int_ff;
  logic [23:0] run_ff = 24'h0;
  logic        last_ff = 1'b0;
  assign src0 = OUTPUT_SOURCE_SELECT[3:0];
  always @(posedge CLK_SYS) begin
    hi_ff <= !RST_N || !OUTPUT_PIN_O[0] ? 24'h0 : hi_ff + 24'h1;
    int_ff <= !RST_N || !INTEGRATION_ACTIVE ? 24'h0 : int_ff + 24'h1;
    run_ff <= INPUT_PIN[0] != last_ff ? 24'h0 : run_ff + {23'h0, ~&run_ff};
    last_ff <= INPUT_PIN[0];
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_integ_end; $fell(INTEGRATION_ACTIVE); endsequence
  sequence s_gap; !TRANSFER_ACTIVE [*8] ##1 TRANSFER_ACTIVE; endsequence
  a_output_enable: assert property ($past(RST_N) |->
    OUTPUT_PIN_OE[0] == $past(PIN_DIRECTION[0] && src0 != `CIT_SRC_OFF)) else $error("output enable wrong");
  a_host_level: assert property ($past(RST_N) && $past(src0 == `CIT_SRC_HOST && PIN_DIRECTION[0]) |->
    OUTPUT_PIN_O[0] == $past(HOST_OUTPUT_LEVEL[0] ^ PIN_POLARITY_FLIP[2])) else $error("host level wrong");
  a_level_follow: assert property ($past(RST_N) && $past(src0 == `CIT_SRC_INTEG_LEVEL && PIN_DIRECTION[0]) |->
    OUTPUT_PIN_O[0] == $past(INTEGRATION_ACTIVE ^ PIN_POLARITY_FLIP[2])) else $error("level output wrong");
  a_soft_start: assert property (SOFTWARE_START && EXTERNAL_START_ENABLE && !FRAME_ACTIVE &&
    START_SOURCE_SELECT == `CIT_TSRC_SOFTWARE |-> ##2 INTEGRATION_ACTIVE) else $error("software start lost");
  a_integ_length: assert property (s_integ_end |-> int_ff == INTEGRATION_TIME * 20 + 1)
    else $error("integration length wrong");
  a_gap_transfer: assert property (s_integ_end |-> s_gap) else $error("transfer gap wrong");
  a_frame_cover: assert property ($fell(TRANSFER_ACTIVE) && !EARLY_START_POLICY && EXTERNAL_START_ENABLE
    |-> !FRAME_ACTIVE) else $error("frame restarted without overlap");
  a_pulse_width: assert property ($fell(OUTPUT_PIN_O[0]) && src0 > 4'h1 && src0 < 4'he && !PIN_POLARITY_FLIP[2]
    |-> hi_ff == PULSE_WIDTH_TIME[15:0] * 20 + 1) else $error("pulse width wrong");
  a_input_filter: assert property ($changed(LINE_STATUS[0]) && $stable(PIN_POLARITY_FLIP[0]) && $past(RST_N)
    |-> run_ff >= INPUT_GLITCH_FILTER_TIME * 20) else $error("input change too early");
endmodule

// >>> verification/test_camera_io_trigger_control.sv
// Self-checking bench: output pulses, host levels, start sources, overlap, free run, input filter.
// Assumes cit_consts.vh on the include path and the grabber model compiled alongside.
`timescale 1ns/1ps
`include "cit_consts.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module test_camera_io_trigger_control;
  logic        CLK_SYS = 0, RST_N = 0, FIRST_TIMER_DONE_EVENT = 0, FIRST_COUNTER_DONE_EVENT = 0;
  logic        SOFTWARE_START = 0, EXTERNAL_START_ENABLE = 1, EARLY_START_POLICY = 0;
  logic [15:0] INPUT_GLITCH_FILTER_TIME = 0, OUTPUT_SOURCE_SELECT = 0;
  logic [5:0]  PIN_POLARITY_FLIP = 0;
  logic [3:0]  PIN_DIRECTION = 4'hf, HOST_OUTPUT_LEVEL = 0;
  logic [7:0]  PULSE_EDGE_SELECT = 0, len = 8'h1e;
  logic [63:0] PULSE_LEAD_TIME = 0, PULSE_WIDTH_TIME = 0;
  logic [2:0]  START_SOURCE_SELECT = `CIT_TSRC_SOFTWARE, go = 0;
  logic [23:0] INTEGRATION_TIME = 0, TRANSFER_TIME = 0, FRAME_PERIOD_TIME = 0;
  wire  [1:0]  INPUT_PIN;
  wire  [3:0]  OUTPUT_PIN_O, OUTPUT_PIN_OE;
  wire  [5:0]  LINE_STATUS;
  wire         LINK_REQUEST_ZERO, FRAME_ACTIVE, INTEGRATION_ACTIVE, TRANSFER_ACTIVE;
  int          fail_count = 0, tests_run = 0, cyc = 0, rise_c = 0, cur_w = 0, er, c0, c1;
  int          exp_rise[$], exp_w[$];
  logic [31:0] seed = 32'hc119;
  logic        mon_on = 0, prev_o = 0, ok;
  logic [3:0]  evs [6] = '{4'hb, 4'hc, 4'hd, 4'h9, 4'ha, 4'h1};
  cit_io_trigger u_cit_io_trigger (.*);
  cit_grabber_model u_cit_grabber_model (.clk(CLK_SYS), .go(go), .len(len), .pin(INPUT_PIN), .link(LINK_REQUEST_ZERO));
  always #25 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s); return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction
  task automatic tick(input int n); repeat (n) @(posedge CLK_SYS); endtask
  task automatic conclude();
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One-cycle event on whatever feeds output source s; software start otherwise
  task automatic fire(input logic [3:0] s);
    @(posedge CLK_SYS);
    case (s)
      4'h9: FIRST_TIMER_DONE_EVENT <= 1'b1;
      4'ha: FIRST_COUNTER_DONE_EVENT <= 1'b1;
      4'hb: go <= 3'b001;
      4'hc: go <= 3'b010;
      4'hd: go <= 3'b100;
      default: SOFTWARE_START <= 1'b1;
    endcase
    @(posedge CLK_SYS);
    {FIRST_TIMER_DONE_EVENT, FIRST_COUNTER_DONE_EVENT, SOFTWARE_START, go} <= 6'h0;
  endtask
  task automatic wait_integ(input int n);
    int k;
    k = 0;
    while (INTEGRATION_ACTIVE === 1'b1 && k < n) begin @(posedge CLK_SYS); k++; end
    while (INTEGRATION_ACTIVE !== 1'b1 && k < n) begin @(posedge CLK_SYS); k++; end
    ok = k < n;
    c0 = cyc;
  endtask
  // Frame sources get a second start inside the frame, which must be turned away
  task automatic pulse(input logic [3:0] s, input logic [1:0] e, input int d);
    int l, w;
    seed = lfsr(seed);
    l = seed[0];
    w = 1 + seed[1];
    @(posedge CLK_SYS);
    OUTPUT_SOURCE_SELECT[3:0] <= s;
    PULSE_EDGE_SELECT[1:0] <= e;
    PULSE_LEAD_TIME[15:0] <= 16'(l);
    PULSE_WIDTH_TIME[15:0] <= 16'(w);
    tick(3);
    exp_w.push_back(w * 20 + 1);
    exp_rise.push_back(d < 0 ? -1 : cyc + 1 + d + l * 20);
    fire(s);
    if (s < 4'h9) fire(s);
    tick(150);
    `CHK("pulse count", 0, exp_rise.size())
  endtask
  task automatic start_chk(input logic [2:0] t, input logic [3:0] ev, input logic e);
    @(posedge CLK_SYS);
    START_SOURCE_SELECT <= t;
    tick(2);
    fire(ev);
    wait_integ(60);
    `CHK("exposure start", e, ok)
    if (e && !ok) conclude();
    tick(40);
  endtask
  always @(negedge CLK_SYS) begin
    if (mon_on && OUTPUT_PIN_O[0] === 1'b1 && prev_o !== 1'b1) begin
      rise_c = cyc;
      `CHK("pulse expected", 1'b1, exp_rise.size() > 0)
      if (exp_rise.size() > 0) begin
        cur_w = exp_w.pop_front();
        er = exp_rise.pop_front();
        if (er >= 0) `CHK("pulse start", er, cyc)
      end
    end
    if (mon_on && OUTPUT_PIN_O[0] !== 1'b1 && prev_o === 1'b1) `CHK("pulse width", cur_w, cyc - rise_c)
    prev_o = OUTPUT_PIN_O[0];
  end
  initial begin
    tick(2);
    RST_N <= 1'b1;
    tick(2);
    #1 `CHK("idle after reset", 5'h0, {FRAME_ACTIVE, OUTPUT_PIN_OE})
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      @(posedge CLK_SYS);
      OUTPUT_SOURCE_SELECT <= 16'h1111;
      HOST_OUTPUT_LEVEL <= seed[3:0];
      PIN_POLARITY_FLIP[2] <= i[0];
      tick(2);
      #1 `CHK("host level", seed[0] ^ i[0], OUTPUT_PIN_O[0])
    end
    @(posedge CLK_SYS);
    OUTPUT_SOURCE_SELECT <= 16'h1110;
    PIN_DIRECTION <= 4'hd;
    tick(2);
    #1 `CHK("drive enables", 4'hc, OUTPUT_PIN_OE)
    @(posedge CLK_SYS);
    OUTPUT_SOURCE_SELECT <= 16'h0;
    PIN_DIRECTION <= 4'hf;
    PIN_POLARITY_FLIP <= 6'h0;
    tick(2);
    mon_on = 1;
    for (int e = 0; e < 3; e++) pulse(4'h9, e[1:0], e == 1 ? 5 : 4);
    pulse(4'ha, 2'h0, 4);
    for (int s = 2; s < 14; s++) if (s != 9 && s != 10) pulse(s[3:0], 2'h0, -1);
    mon_on = 0;
    for (int t = 0; t < 6; t++) start_chk(t[2:0], evs[t], 1'b1);
    start_chk(`CIT_TSRC_PIN_ONE, 4'h9, 1'b0);
    START_SOURCE_SELECT <= `CIT_TSRC_SOFTWARE;
    TRANSFER_TIME <= 24'h1;
    for (int p = 0; p < 2; p++) begin
      EARLY_START_POLICY <= p[0];
      tick(2);
      fire(4'h1);
      tick(14);
      fire(4'h1);
      tick(20);
      #1 `CHK("overlap restart", p[0], FRAME_ACTIVE)
      tick(60);
    end
    OUTPUT_SOURCE_SELECT[3:0] <= `CIT_SRC_INTEG_LEVEL;
    INTEGRATION_TIME <= 24'h1;
    FRAME_PERIOD_TIME <= 24'h3;
    EXTERNAL_START_ENABLE <= 1'b0;
    wait_integ(200);
    `CHK("free run start", 1'b1, ok)
    c1 = c0;
    wait_integ(200);
    `CHK("free run restart", 1'b1, ok)
    if (!ok) conclude();
    `CHK("frame period", 80, c0 - c1)
    EXTERNAL_START_ENABLE <= 1'b1;
    INPUT_GLITCH_FILTER_TIME <= 16'h1;
    PIN_POLARITY_FLIP <= 6'h01;
    tick(3);
    #1 `CHK("inverted idle input", 1'b1, LINE_STATUS[0])
    len <= 8'h0a;
    for (int g = 0; g < 2; g++) begin
      @(posedge CLK_SYS);
      go <= 3'b001;
      @(posedge CLK_SYS);
      go <= 3'b000;
      tick(30);
      #1 `CHK("filtered input", !g[0], LINE_STATUS[0])
      len <= 8'h28;
    end
    conclude();
  end
endmodule
bind cit_io_trigger cit_io_trigger_sva #(.NIN(NIN), .NOUT(NOUT)) u_cit_io_trigger_sva (.*);
